// ===== rtl/ripc_pkg.sv
// What this block does
// - reset restarts CPU fetching at address zero
// - reset comes from pin or watchdog
// - watchdog drives reset pin for 96 clocks
// - in reset port 0 and card pins float, ports 1 to 5 high
// - idle and power-down keep last pin data
// - clocks divide by two unless double speed
// - idle stops CPU clock, peripherals keep running
// - idle keeps CPU state, registers and RAM
// - idle request enters idle after the write
// - both requests set: power-down, never idle after
// - interrupt in idle clears request, restarts CPU
// - two general flags for software use
// - reset pin clears idle, restarts CPU clock
// - RAM blocked between wake and internal reset
// - power-down stops oscillator and all clocks
// - power-down retains all CPU state
// - boot map enable loaded from fuse bit
// - power control layout; power-down wins
// - keypad wake waits 1024 clocks
package ripc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PCR_OFF  = 8'h00;
  localparam logic [7:0] AUX_OFF  = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;

  localparam int SDR_BIT = 7;
  localparam int FES_BIT = 6;
  localparam int GF1_BIT = 3;
  localparam int GF0_BIT = 2;
  localparam int PD_BIT  = 1;
  localparam int IDL_BIT = 0;
  localparam logic [7:0] PCR_RST   = 8'h00;
  localparam logic [7:0] PCR_WMASK = 8'hCF;
  localparam logic [7:0] PCR_MODES = 8'h03;

  localparam int BOOT_BIT = 0;
  localparam int X2_BIT   = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing counts in oscillator clocks, and CPU start address
  // ----------------------------------------------------------------
  localparam logic [4:0]  RST_MIN_CYC  = 5'h18;
  localparam logic [6:0]  WDT_PULSE_CYC = 7'h60;
  localparam logic [10:0] KEY_WAKE_CYC = 11'h400;
  localparam logic [15:0] START_ADDR   = 16'h0000;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_IDLE   = 3'b001,
    ST_PD     = 3'b010,
    ST_PD_INT = 3'b011,
    ST_PD_KEY = 3'b100
  } ripc_state_t;

endpackage

// ===== rtl/ripc_rst_sync.sv
`timescale 1ns/1ps
module ripc_rst_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // reset pin and watchdog
  input  wire logic rst_pin_i,
  input  wire logic wdt_fire,
  output logic      pin_hi,
  output logic      core_rst,
  output logic      pin_oe
);
  import ripc_pkg::*;

  logic       s1_q, s2_q;
  logic [4:0] cnt_q, cnt_d;
  logic [6:0] wdt_q, wdt_d;
  logic       core_q, core_d;

  always_comb begin
    cnt_d = 5'h00;
    if (s2_q) begin
      cnt_d = (cnt_q == RST_MIN_CYC) ? cnt_q : cnt_q + 5'h01;
    end
    wdt_d = (wdt_q != 7'h00) ? wdt_q - 7'h01 : 7'h00;
    if (wdt_fire && wdt_q == 7'h00) begin
      wdt_d = WDT_PULSE_CYC;
    end
    core_d = (cnt_q == RST_MIN_CYC) || (wdt_q != 7'h00);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      cnt_q  <= 5'h00;
      wdt_q  <= 7'h00;
      core_q <= 1'b1;
    end else begin
      s1_q   <= rst_pin_i;
      s2_q   <= s1_q;
      cnt_q  <= cnt_d;
      wdt_q  <= wdt_d;
      core_q <= core_d;
    end
  end

  assign pin_hi   = s2_q;
  assign core_rst = core_q;
  assign pin_oe   = (wdt_q != 7'h00);

  a_wdt_width: assert property (@(posedge clk) disable iff (rst)
    $rose(pin_oe) |-> ##95 pin_oe ##1 !pin_oe)
    else $error("watchdog pulse not 96 clocks");

endmodule

// ===== rtl/ripc_axil.sv
`timescale 1ns/1ps
module ripc_axil (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // register side
  output logic             wr_pulse,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  import ripc_pkg::*;

  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  a_q, a_d;
  logic [31:0] d_q, d_d, rd_q, rd_d;
  logic [3:0]  st_q, st_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;

  assign s_awready = !aw_q && !bv_q;
  assign s_wready  = !w_q && !bv_q;
  assign s_arready = !rv_q;
  assign wr_pulse  = aw_q && w_q;
  assign rd_addr   = s_araddr;

  always_comb begin
    aw_d = aw_q; w_d = w_q; a_d = a_q; d_d = d_q; st_d = st_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    if (s_awvalid && s_awready) begin
      aw_d = 1'b1;
      a_d  = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_d  = 1'b1;
      d_d  = s_wdata;
      st_d = s_wstrb;
    end
    if (wr_pulse) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bv_q && s_bready) begin
      bv_d = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      rv_d = 1'b1;
      rd_d = rd_data;
      rr_d = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rv_q && s_rready) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      a_q  <= 8'h00; d_q <= 32'h0000_0000; st_q <= 4'h0;
      br_q <= RESP_OKAY; rr_q <= RESP_OKAY; rd_q <= 32'h0000_0000;
    end else begin
      aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
      a_q  <= a_d; d_q <= d_d; st_q <= st_d;
      br_q <= br_d; rr_q <= rr_d; rd_q <= rd_d;
    end
  end

  assign wr_addr  = a_q;
  assign wr_data  = d_q;
  assign wr_strb  = st_q;
  assign s_bvalid = bv_q;
  assign s_bresp  = br_q;
  assign s_rvalid = rv_q;
  assign s_rresp  = rr_q;
  assign s_rdata  = rd_q;

endmodule

// ===== rtl/ripc_top.sv
`timescale 1ns/1ps
module ripc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // reset pin, open drain high drive
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  // reset and wake sources
  input  wire logic        wdt_fire,
  input  wire logic        irq_wake,
  input  wire logic        keypad_wake_inputs,
  input  wire logic        boot_jump_fuse_bit,
  // clocks and cpu control
  output logic             osc_enable,
  output logic             cpu_clk_en,
  output logic             per_clk_en,
  output logic             cpu_rst,
  output logic [15:0]      cpu_start_addr,
  output logic             ram_block,
  output logic             boot_map_enable,
  output logic             serial_double_rate_bit,
  output logic             frame_error_select_bit,
  // port pins
  input  wire logic [47:0] port_data,
  output logic [47:0]      port_out,
  output logic [47:0]      port_oe,
  input  wire logic [7:0]  card_data,
  output logic [7:0]       card_out,
  output logic [7:0]       card_oe
);
  import ripc_pkg::*;

  // ----------------------------------------------------------------
  // reset synchroniser and watchdog pulse
  // ----------------------------------------------------------------
  logic pin_hi;
  logic core_rst;

  ripc_rst_sync u_rsync (
    .clk       (clk),
    .rst       (rst),
    .rst_pin_i (rst_pin_in),
    .wdt_fire  (wdt_fire),
    .pin_hi    (pin_hi),
    .core_rst  (core_rst),
    .pin_oe    (rst_pin_oe)
  );

  assign rst_pin_out = 1'b1;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic        wr_pulse;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  ripc_axil u_axil (
    .clk       (clk),
    .rst       (rst),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_pulse  (wr_pulse),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_err    (wr_err),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  // ----------------------------------------------------------------
  // power state, control registers
  // ----------------------------------------------------------------
  ripc_state_t st_q, st_d;
  logic [7:0]  pcr_q, pcr_d;
  logic        boot_q, boot_d;
  logic        x2_q, x2_d;
  logic        rblk_q, rblk_d;
  logic [10:0] kcnt_q, kcnt_d;
  logic        pcr_wr, aux_wr;
  logic [7:0]  pcr_new;

  assign pcr_wr  = wr_pulse && wr_addr == PCR_OFF && wr_strb[0];
  assign aux_wr  = wr_pulse && wr_addr == AUX_OFF && wr_strb[0];
  assign pcr_new = (pcr_q & ~PCR_WMASK) | (wr_data[7:0] & PCR_WMASK);
  assign wr_err  = !(wr_addr == PCR_OFF || wr_addr == AUX_OFF);

  always_comb begin
    st_d   = st_q;
    pcr_d  = pcr_q;
    boot_d = boot_q;
    x2_d   = x2_q;
    rblk_d = rblk_q;
    kcnt_d = kcnt_q;
    if (core_rst) begin
      st_d   = ST_RUN;
      pcr_d  = PCR_RST;
      boot_d = boot_jump_fuse_bit;
      x2_d   = 1'b0;
      rblk_d = 1'b0;
      kcnt_d = 11'h000;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (pcr_wr) begin
            pcr_d = pcr_new;
            if (pcr_new[PD_BIT]) begin
              st_d = ST_PD;
            end else if (pcr_new[IDL_BIT]) begin
              st_d = ST_IDLE;
            end
          end
          if (aux_wr) begin
            boot_d = wr_data[BOOT_BIT];
            x2_d   = wr_data[X2_BIT];
          end
        end
        ST_IDLE: begin
          if (pin_hi) begin
            pcr_d  = pcr_q & ~PCR_MODES;
            st_d   = ST_RUN;
            rblk_d = 1'b1;
          end else if (irq_wake) begin
            pcr_d = pcr_q & ~PCR_MODES;
            st_d  = ST_RUN;
          end
        end
        ST_PD: begin
          if (pin_hi) begin
            pcr_d  = pcr_q & ~PCR_MODES;
            st_d   = ST_RUN;
            rblk_d = 1'b1;
          end else if (keypad_wake_inputs) begin
            st_d   = ST_PD_KEY;
            kcnt_d = 11'h000;
          end else if (irq_wake) begin
            st_d = ST_PD_INT;
          end
        end
        ST_PD_INT: begin
          if (pin_hi || !irq_wake) begin
            pcr_d = pcr_q & ~PCR_MODES;
            st_d  = ST_RUN;
            rblk_d = pin_hi;
          end
        end
        ST_PD_KEY: begin
          kcnt_d = kcnt_q + 11'h001;
          if (kcnt_d == KEY_WAKE_CYC || pin_hi) begin
            pcr_d = pcr_q & ~PCR_MODES;
            st_d  = ST_RUN;
            rblk_d = pin_hi;
          end
        end
        default: begin
          st_d = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= ST_RUN;
      pcr_q  <= PCR_RST;
      boot_q <= 1'b0;
      x2_q   <= 1'b0;
      rblk_q <= 1'b0;
      kcnt_q <= 11'h000;
    end else begin
      st_q   <= st_d;
      pcr_q  <= pcr_d;
      boot_q <= boot_d;
      x2_q   <= x2_d;
      rblk_q <= rblk_d;
      kcnt_q <= kcnt_d;
    end
  end

  // ----------------------------------------------------------------
  // clock enables
  // ----------------------------------------------------------------
  logic div_q, div_d;
  logic osc_on;

  assign osc_on = (st_q != ST_PD);

  always_comb begin
    div_d = osc_on ? !div_q : div_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 1'b0;
    end else begin
      div_q <= div_d;
    end
  end

  // cpu and peripherals freeze while any power-down state holds
  assign per_clk_en = osc_on && (x2_q || div_q) &&
                      st_q != ST_PD_INT && st_q != ST_PD_KEY;
  assign cpu_clk_en = per_clk_en && st_q == ST_RUN;

  assign osc_enable             = osc_on;
  assign cpu_rst                = core_rst;
  assign cpu_start_addr         = START_ADDR;
  assign ram_block              = rblk_q;
  assign boot_map_enable        = boot_q;
  assign serial_double_rate_bit = pcr_q[SDR_BIT];
  assign frame_error_select_bit = pcr_q[FES_BIT];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (rd_addr)
      PCR_OFF:  rd_data[7:0] = pcr_q;
      AUX_OFF:  rd_data[1:0] = {x2_q, boot_q};
      STAT_OFF: rd_data[4:0] = {st_q, rblk_q, core_rst};
      default:  rd_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // port pins
  // ----------------------------------------------------------------
  logic [47:0] pout_q, pout_d, poe_q, poe_d;
  logic [7:0]  cout_q, cout_d, coe_q, coe_d;

  // port 0 is open drain, ports 1 to 5 push data
  for (genvar p = 0; p < 6; p++) begin : g_port
    always_comb begin
      if (core_rst) begin
        pout_d[p*8 +: 8] = 8'hFF;
        poe_d[p*8 +: 8]  = (p == 0) ? 8'h00 : 8'hFF;
      end else begin
        pout_d[p*8 +: 8] = port_data[p*8 +: 8];
        poe_d[p*8 +: 8]  = (p == 0) ? ~port_data[7:0] : 8'hFF;
      end
    end
  end

  always_comb begin
    cout_d = core_rst ? 8'hFF : card_data;
    coe_d  = core_rst ? 8'h00 : 8'hFF;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pout_q <= 48'hFFFF_FFFF_FFFF;
      poe_q  <= 48'hFFFF_FFFF_FF00;
      cout_q <= 8'hFF;
      coe_q  <= 8'h00;
    end else begin
      pout_q <= pout_d;
      poe_q  <= poe_d;
      cout_q <= cout_d;
      coe_q  <= coe_d;
    end
  end

  assign port_out = pout_q;
  assign port_oe  = poe_q;
  assign card_out = cout_q;
  assign card_oe  = coe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_idle_req;
    st_q == ST_RUN && !core_rst && pcr_wr &&
    pcr_new[IDL_BIT] && !pcr_new[PD_BIT];
  endsequence

  sequence s_both_req;
    st_q == ST_RUN && !core_rst && pcr_wr &&
    pcr_new[IDL_BIT] && pcr_new[PD_BIT];
  endsequence

  a_reset_vector: assert property (
    $fell(cpu_rst) |-> st_q == ST_RUN && pcr_q == PCR_RST &&
    cpu_start_addr == 16'h0000)
    else $error("bad state after reset");
  a_wdt_reset: assert property (
    wdt_fire && !rst_pin_oe |=> ##1 cpu_rst)
    else $error("watchdog did not reset core");
  a_reset_pins: assert property (
    cpu_rst |=> port_oe[7:0] == 8'h00 && port_out[47:8] == 40'hFF_FFFF_FFFF
    && port_oe[47:8] == 40'hFF_FFFF_FFFF && card_oe == 8'h00)
    else $error("pins wrong during reset");
  a_idle_pins: assert property (
    st_q != ST_RUN && !cpu_rst |=> port_out == $past(port_data))
    else $error("pins lost data in low power");
  a_div_two: assert property (
    per_clk_en && !x2_q && !x2_d |=> !per_clk_en)
    else $error("clock not divided by two");
  a_idle_gate: assert property (
    st_q == ST_IDLE |-> !cpu_clk_en && (per_clk_en || $past(per_clk_en)))
    else $error("idle clock gating wrong");
  a_idle_entry: assert property (
    s_idle_req |=> st_q == ST_IDLE && pcr_q[IDL_BIT])
    else $error("idle not entered");
  a_pd_wins: assert property (
    s_both_req |=> st_q == ST_PD ##0 (st_q != ST_IDLE)[*8])
    else $error("power-down did not win");
  a_idle_wake: assert property (
    st_q == ST_IDLE && irq_wake && !pin_hi && !core_rst
    |=> st_q == ST_RUN && !pcr_q[IDL_BIT] && !pcr_q[PD_BIT])
    else $error("interrupt did not end idle");
  a_pin_wake: assert property (
    st_q == ST_IDLE && pin_hi && !core_rst
    |=> st_q == ST_RUN && ram_block ##0 ram_block[*2])
    else $error("reset pin did not wake");
  a_pd_stop: assert property (
    st_q == ST_PD |-> !osc_enable && !per_clk_en && !cpu_clk_en)
    else $error("clocks run in power-down");
  a_boot_load: assert property (
    $fell(cpu_rst) |-> boot_map_enable == $past(boot_jump_fuse_bit))
    else $error("boot map not loaded from fuse");
  a_key_wait: assert property (
    st_q == ST_PD_KEY && kcnt_q < 11'h3FF && !pin_hi && !core_rst
    |=> st_q == ST_PD_KEY && !cpu_clk_en)
    else $error("keypad wake resumed early");

endmodule

// ===== tb/ripc_far_side.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// reset circuit and wake sources outside the device
// --------------------------------------------------------------
module ripc_far_side (
  // bench commands
  input  wire logic press,
  input  wire logic irq_req,
  input  wire logic key_req,
  // device side
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  output logic      rst_pin_in,
  output logic      irq_wake,
  output logic      keypad_wake_inputs
);
  // pin has a pull-down: low unless pressed or driven by the device
  assign rst_pin_in = (rst_pin_oe & rst_pin_out) | press;
  // interrupt and keypad sources are levels held by the bench
  assign irq_wake           = irq_req;
  assign keypad_wake_inputs = key_req;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ripc_pkg::*;
  logic        clk, rst, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr, card_data, card_out, card_oe;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        rst_pin_in, rst_pin_out, rst_pin_oe, wdt_fire, irq_wake;
  logic        keypad_wake_inputs, press, irq_req, key_req, fuse;
  logic        osc_enable, cpu_clk_en, per_clk_en, cpu_rst, ram_block;
  logic        boot_map_enable, serial_double_rate_bit, frame_error_select_bit;
  logic [15:0] cpu_start_addr;
  logic [47:0] port_data, port_out, port_oe;
  int          bad_count, n_tests, cyc, n, c, p;

  ripc_top i_dut (
    .clk(clk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .wdt_fire(wdt_fire), .irq_wake(irq_wake),
    .keypad_wake_inputs(keypad_wake_inputs), .boot_jump_fuse_bit(fuse),
    .osc_enable(osc_enable), .cpu_clk_en(cpu_clk_en),
    .per_clk_en(per_clk_en), .cpu_rst(cpu_rst),
    .cpu_start_addr(cpu_start_addr), .ram_block(ram_block),
    .boot_map_enable(boot_map_enable),
    .serial_double_rate_bit(serial_double_rate_bit),
    .frame_error_select_bit(frame_error_select_bit),
    .port_data(port_data), .port_out(port_out), .port_oe(port_oe),
    .card_data(card_data), .card_out(card_out), .card_oe(card_oe));

  ripc_far_side i_far (
    .press(press), .irq_req(irq_req), .key_req(key_req),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .rst_pin_in(rst_pin_in), .irq_wake(irq_wake),
    .keypad_wake_inputs(keypad_wake_inputs));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up;
    end
  end

  task automatic chk(input logic [47:0] g, input logic [47:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_awready === 1'b1) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w && s_wready === 1'b1) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    chk(s_bresp, er, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge clk); while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    chk(s_rdata, e, "rdata");
    chk(s_rresp, er, "rresp");
  endtask

  // counts clock enables over eight edges
  task automatic cnt;
    c = 0;
    p = 0;
    repeat (8) begin
      @(posedge clk);
      if (cpu_clk_en === 1'b1) c++;
      if (per_clk_en === 1'b1) p++;
    end
  endtask

  initial begin
    rst = 1'b1;
    fuse = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {wdt_fire, press, irq_req, key_req} = 4'h0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
    port_data = 48'h123456789A5C;
    card_data = 8'hA5;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    chk(port_oe, 48'hFFFFFFFFFF00, "port oe");
    chk(port_out | 48'hFF, 48'hFFFFFFFFFFFF, "port out");
    chk(card_oe, 8'h00, "card oe");
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(cpu_start_addr, START_ADDR, "start");
    rd(PCR_OFF, 32'h0, RESP_OKAY);
    rd(AUX_OFF, 32'h1, RESP_OKAY);
    rd(STAT_OFF, 32'h0, RESP_OKAY);
    wr(PCR_OFF, 32'hFC, RESP_OKAY);
    rd(PCR_OFF, 32'hCC, RESP_OKAY);
    chk({serial_double_rate_bit, frame_error_select_bit}, 2'h3, "smod");
    wr(AUX_OFF, 32'h3, RESP_OKAY);
    cnt;
    chk(p, 8, "x2 rate");
    chk(c, 8, "cpu x2");
    wr(AUX_OFF, 32'h1, RESP_OKAY);
    cnt;
    chk(p, 4, "x1 rate");
    wr(PCR_OFF, 32'hCD, RESP_OKAY);
    cnt;
    chk(c, 0, "idle cpu clock");
    chk(p, 4, "idle per clock");
    chk({port_out, card_out}, {port_data, card_data}, "idle pins");
    rd(STAT_OFF, 32'h4, RESP_OKAY);
    wr(PCR_OFF, 32'h0, RESP_OKAY);
    irq_req <= 1'b1;
    repeat (2) @(posedge clk);
    irq_req <= 1'b0;
    rd(PCR_OFF, 32'hCC, RESP_OKAY);
    wr(PCR_OFF, 32'hCF, RESP_OKAY);
    rd(STAT_OFF, 32'h8, RESP_OKAY);
    chk({osc_enable, per_clk_en}, 2'h0, "pd clocks");
    rd(PCR_OFF, 32'hCF, RESP_OKAY);
    irq_req <= 1'b1;
    repeat (3) @(posedge clk);
    rd(STAT_OFF, 32'hC, RESP_OKAY);
    irq_req <= 1'b0;
    repeat (3) @(posedge clk);
    rd(STAT_OFF, 32'h0, RESP_OKAY);
    rd(PCR_OFF, 32'hCC, RESP_OKAY);
    wr(AUX_OFF, 32'h3, RESP_OKAY);
    wr(PCR_OFF, 32'hCE, RESP_OKAY);
    key_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (per_clk_en !== 1'b1 && n < 2000);
    key_req <= 1'b0;
    chk(n >= 1024 && n <= 1030, 1'b1, "key wait");
    fuse <= 1'b0;
    wdt_fire <= 1'b1;
    @(posedge clk);
    wdt_fire <= 1'b0;
    do @(posedge clk); while (rst_pin_oe !== 1'b1);
    n = 0;
    while (rst_pin_oe === 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(n, 96, "wdt pulse");
    chk(cpu_rst, 1'b1, "wdt reset");
    do @(posedge clk); while (cpu_rst !== 1'b0);
    rd(AUX_OFF, 32'h0, RESP_OKAY);
    chk(boot_map_enable, 1'b0, "boot reload");
    wr(PCR_OFF, 32'h1, RESP_OKAY);
    press <= 1'b1;
    repeat (5) @(posedge clk);
    chk({ram_block, cpu_rst}, 2'h2, "pin wake");
    repeat (15) @(posedge clk);
    chk(cpu_rst, 1'b0, "short pin");
    repeat (12) @(posedge clk);
    chk(cpu_rst, 1'b1, "long pin");
    press <= 1'b0;
    do @(posedge clk); while (cpu_rst !== 1'b0);
    chk(ram_block, 1'b0, "ram open");
    rd(PCR_OFF, 32'h0, RESP_OKAY);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wr(STAT_OFF, 32'h1, RESP_SLVERR);
    wrap_up;
  end
endmodule
